// >>> src/usp_params.svh
// Constants for the user sense and enable port
`ifndef USP_PARAMS_SVH
`define USP_PARAMS_SVH

`define USP_ADDR_W        5
`define USP_DATA_W        8
`define USP_UDR_ADDR      5'h17
`define USP_UDR_RESET     8'h00
`define USP_RDATA_IDLE    8'h00
`define USP_BIT_EN2       6
`define USP_BIT_SENSE2    4
`define USP_BIT_EN1       3
`define USP_BIT_EN0       2
`define USP_CLK_MHZ       200
`define USP_SENSE_MIN_NS  1000
`define USP_NS_PER_US     1000
`define USP_SENSE_MIN_CYC ((`USP_SENSE_MIN_NS * `USP_CLK_MHZ + `USP_NS_PER_US - 1) / `USP_NS_PER_US)
`define USP_CNT_W         12
`define USP_DUAL_PATH     1

`endif

// >>> src/usp_pkg.sv
// Types and helpers for the user sense and enable port
`include "usp_params.svh"

package usp_pkg;

	typedef struct packed {
		logic res7;
		logic en2;
		logic res5;
		logic sense2;
		logic en1;
		logic en0;
		logic sense1;
		logic sense0;
	} usp_udr_t;

	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [`USP_ADDR_W-1:0] addr;
		logic [`USP_DATA_W-1:0] wdata;
	} usp_req_t;

	function automatic logic usp_hit(input logic [`USP_ADDR_W-1:0] addr,
	                                 input logic [`USP_ADDR_W-1:0] offset);
		usp_hit = (addr == offset);
	endfunction

endpackage

// >>> src/usp_sync.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps

module usp_sync
	import usp_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic async_in,
	output logic      sync_out
);

	logic stage1;

	// Stage one feeds only stage two
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // usp_sync

// >>> src/usp_qualify.sv
// Minimum high-time qualifier for a synchronised sense level
`timescale 1ns/1ps
`include "usp_params.svh"

module usp_qualify
	import usp_pkg::*;
#(
	parameter int unsigned MIN_CYC = 1
)
(
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic level,
	output logic      qualified
);

	// Count sits at LAST_C in the last required high cycle, so exactly MIN_CYC cycles qualify
	localparam logic [`USP_CNT_W-1:0] LAST_C = `USP_CNT_W'(MIN_CYC - 1);

	logic [`USP_CNT_W-1:0] count;
	logic [`USP_CNT_W-1:0] next_count;
	wire                   at_min;

	// Saturates so a long assertion never wraps and re-arms
	assign at_min     = (count == LAST_C);
	assign next_count = !level ? '0 : (at_min ? count : count + 1'b1);
	assign qualified  = at_min & level;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			count <= '0;
		else
			count <= next_count;
	end

endmodule // usp_qualify

// >>> src/usp_user_port.sv
// User sense and enable port with its control bus register
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "usp_params.svh"

module usp_user_port
	import usp_pkg::*;
#(
	parameter int unsigned SENSE_MIN_CYC = `USP_SENSE_MIN_CYC,
	parameter bit          DUAL_PATH     = `USP_DUAL_PATH
)
(
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	input  wire logic [`USP_ADDR_W-1:0] reg_addr,
	input  wire logic [`USP_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [`USP_DATA_W-1:0] reg_rdata,
	input  wire logic                   user_sense_in_2,
	output logic                        user_enable_out_0,
	output logic                        user_enable_out_1,
	output logic                        user_enable_out_2
);

	localparam usp_udr_t UDR_RST = usp_udr_t'(`USP_UDR_RESET);

	usp_req_t req;
	usp_udr_t wr_fields;
	usp_udr_t rd_fields;

	logic user_enable_ctl_0;
	logic user_enable_ctl_1;
	logic user_enable_ctl_2;
	logic user_sense_flag_2;

	logic next_enable_ctl_0;
	logic next_enable_ctl_1;
	logic next_enable_ctl_2;
	logic next_sense_flag_2;
	logic [`USP_DATA_W-1:0] next_rdata;

	wire  sense_level;
	wire  sense_qualified;
	wire  udr_hit;
	wire  udr_write;
	wire  udr_read;
	wire  clear_request;
	wire  clear_allowed;
	wire  set_event;

	assign req.wr    = reg_wr;
	assign req.rd    = reg_rd;
	assign req.addr  = reg_addr;
	assign req.wdata = reg_wdata;

	usp_sync u_sense_sync
	(
		.core_clk (core_clk),
		.rstn     (rstn),
		.async_in (user_sense_in_2),
		.sync_out (sense_level)
	);

	usp_qualify #(
		.MIN_CYC (SENSE_MIN_CYC)
	) u_sense_qualify
	(
		.core_clk  (core_clk),
		.rstn      (rstn),
		.level     (sense_level),
		.qualified (sense_qualified)
	);

	// Register decode
	assign udr_hit   = usp_hit(req.addr, `USP_UDR_ADDR);
	assign udr_write = req.wr & udr_hit;
	assign udr_read  = req.rd & udr_hit;
	assign wr_fields = usp_udr_t'(req.wdata);

	// Enable bits; enable 2 stays low on the single-path variant
	assign next_enable_ctl_0 = udr_write ? wr_fields.en0 : user_enable_ctl_0;
	assign next_enable_ctl_1 = udr_write ? wr_fields.en1 : user_enable_ctl_1;
	assign next_enable_ctl_2 = !DUAL_PATH ? 1'b0 : (udr_write ? wr_fields.en2 : user_enable_ctl_2);

	// Writing 0 asks for a clear; it only takes while the synchronised pin is low,
	// so the event source stays visible until the outside logic drops its request
	assign clear_request = udr_write & ~wr_fields.sense2;
	assign clear_allowed = clear_request & ~sense_level;
	assign set_event     = sense_qualified & DUAL_PATH;

	// Set wins over a clear in the same cycle
	assign next_sense_flag_2 = set_event ? 1'b1 : (clear_allowed ? 1'b0 : user_sense_flag_2);

	// Read view; reserved and unused sense bits read as zero
	always_comb
	begin
		rd_fields        = UDR_RST;
		rd_fields.en0    = user_enable_ctl_0;
		rd_fields.en1    = user_enable_ctl_1;
		rd_fields.en2    = user_enable_ctl_2;
		rd_fields.sense2 = user_sense_flag_2;
	end

	// Unmapped reads answer zero; data stands for one cycle only
	assign next_rdata = udr_read ? `USP_DATA_W'(rd_fields) : `USP_RDATA_IDLE;

	// One short block per register; UDR bits reset from the register's reset word, reg_rdata from the idle value
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			user_enable_ctl_0 <= UDR_RST.en0;
		else
			user_enable_ctl_0 <= next_enable_ctl_0;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			user_enable_ctl_1 <= UDR_RST.en1;
		else
			user_enable_ctl_1 <= next_enable_ctl_1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			user_enable_ctl_2 <= UDR_RST.en2;
		else
			user_enable_ctl_2 <= next_enable_ctl_2;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			user_sense_flag_2 <= UDR_RST.sense2;
		else
			user_sense_flag_2 <= next_sense_flag_2;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= `USP_RDATA_IDLE;
		else
			reg_rdata <= next_rdata;
	end

	// Pins come straight from the control flops
	assign user_enable_out_0 = user_enable_ctl_0;
	assign user_enable_out_1 = user_enable_ctl_1;
	assign user_enable_out_2 = user_enable_ctl_2;

endmodule // usp_user_port

// >>> verif/usp_monitor.sv
// Port checker for the user sense and enable port
`timescale 1ns/1ps
module usp_monitor
	import usp_pkg::*;
#(parameter int unsigned SENSE_MIN_CYC = 4, parameter bit DUAL_PATH = 1)
(
	input logic       core_clk,
	input logic       rstn,
	input logic [4:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [7:0] reg_rdata,
	input logic       user_sense_in_2,
	input logic       user_enable_out_0,
	input logic       user_enable_out_1,
	input logic       user_enable_out_2
);
	logic [6:0] hi, lo;
	logic       armed;
	wire        wr17 = reg_wr && reg_addr == 5'h17;
	wire        rd17 = reg_rd && reg_addr == 5'h17;
	// Runs saturate; armed is lenient on clears so it only guards false sets
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			{hi, lo, armed} <= '0;
		else
		begin
			hi <= user_sense_in_2 ? hi + 7'(!(&hi)) : 7'h00;
			lo <= user_sense_in_2 ? 7'h00 : lo + 7'(!(&lo));
			armed <= hi >= SENSE_MIN_CYC || (armed && !(wr17 && !reg_wdata[4] && lo > 3));
		end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	en0_follow_a: assert property (wr17 |=> user_enable_out_0 == $past(reg_wdata[2])) else $error("en0");
	en1_follow_a: assert property (wr17 |=> user_enable_out_1 == $past(reg_wdata[3])) else $error("en1");
	en2_follow_a: assert property (wr17 |=> user_enable_out_2 == (DUAL_PATH && $past(reg_wdata[6])))
		else $error("en2");
	flag_set_a: assert property (DUAL_PATH && rd17 && hi > SENSE_MIN_CYC + 4 |=> reg_rdata[4])
		else $error("unset");
	single_path_a: assert property (!DUAL_PATH |-> !user_enable_out_2 && !reg_rdata[4] && !reg_rdata[6])
		else $error("single path bit active");
	flag_clear_a: assert property (wr17 && !reg_wdata[4] && lo > 3 ##1 rd17 |=> !reg_rdata[4])
		else $error("kept");
	short_pulse_a: assert property (rd17 && !armed |=> !reg_rdata[4]) else $error("early");
endmodule // usp_monitor
bind usp_user_port usp_monitor #(.SENSE_MIN_CYC(SENSE_MIN_CYC), .DUAL_PATH(DUAL_PATH)) mon (.core_clk, .rstn, .reg_addr,
	.reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .user_sense_in_2, .user_enable_out_0, .user_enable_out_1, .user_enable_out_2);

// >>> verif/usp_ext_logic.sv
// Model of the outside logic that drives sense pin 2
`timescale 1ns/1ps
module usp_ext_logic
	import usp_pkg::*;
(
	input  logic       core_clk,
	input  logic       start,
	input  logic [7:0] len,
	output logic       user_sense_in_2
);
	logic [7:0] left = 8'h00;
	// Pin is pulled low while idle
	always @(posedge core_clk)
		left <= start ? len : left - 8'(|left);
	assign user_sense_in_2 = |left;
endmodule // usp_ext_logic

// >>> verif/user_sense_enable_pins_test.sv
// Self-checking bench for the user sense and enable port
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; $display("wrong value %s %h %h", n, e, s); end end
module user_sense_enable_pins_test
	import usp_pkg::*;
;
	localparam int unsigned MIN = 4;
	logic       core_clk, rstn, reg_wr, reg_rd, start, user_sense_in_2;
	logic       user_enable_out_0, user_enable_out_1, user_enable_out_2;
	logic       sp_en0, sp_en1, sp_en2;
	logic [7:0] sp_rdata;
	logic [4:0] reg_addr, a;
	logic [7:0] reg_wdata, reg_rdata, len, d;
	usp_udr_t   model;
	int         err_count, checks, cyc;
	wire  [2:0] ens = {user_enable_out_2, user_enable_out_1, user_enable_out_0};
	usp_user_port #(.SENSE_MIN_CYC(MIN)) dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.user_sense_in_2, .user_enable_out_0, .user_enable_out_1, .user_enable_out_2);
	// Single-path variant sees the same bus and pin
	usp_user_port #(.SENSE_MIN_CYC(MIN), .DUAL_PATH(1'b0)) dut_single (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata(sp_rdata), .user_sense_in_2, .user_enable_out_0(sp_en0), .user_enable_out_1(sp_en1),
		.user_enable_out_2(sp_en2));
	usp_ext_logic ext (.core_clk, .start, .len, .user_sense_in_2);
	function automatic logic [7:0] udr(input logic f);
		udr = {1'b0, model.en2, 1'b0, f, model.en1, model.en0, 2'b00};
	endfunction
	task automatic print_verdict();
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [7:0] v);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, v};
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] ad, input logic [7:0] e);
		{reg_rd, reg_addr} <= {1'b1, ad};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, reg_rdata)
		`CHK("single-path rdata", e & 8'hAF, sp_rdata)
		@(posedge core_clk);
	endtask
	// Outside logic holds the pin high for n cycles
	task automatic pulse(input logic [7:0] n);
		{start, len} <= {1'b1, n};
		@(posedge core_clk);
		start <= 1'b0;
		repeat (MIN + 8) @(posedge core_clk);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (++cyc > 3000)
		begin
			err_count++;
			print_verdict();
		end
	initial
	begin
		{rstn, reg_wr, reg_rd, start, reg_addr, reg_wdata, len} = '0;
		model = '0;
		void'($urandom(72670));
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		rd(5'h17, udr(1'b0));
		`CHK("reset enables", 3'b000, ens)
		repeat (30)
		begin
			a = $urandom_range(1) ? 5'h17 : 5'($urandom);
			d = 8'($urandom);
			wr(a, d);
			if (a == 5'h17)
				model = {d[7:5], 1'b0, d[3:0]};
			rd(a, a == 5'h17 ? udr(1'b0) : 8'h00);
			`CHK("enables", {model.en2, model.en1, model.en0}, ens)
			`CHK("single-path enables", {1'b0, model.en1, model.en0}, {sp_en2, sp_en1, sp_en0})
		end
		pulse(8'(MIN - 1));
		rd(5'h17, udr(1'b0));
		pulse(8'h28);
		wr(5'h17, model);
		rd(5'h17, udr(1'b1));
		repeat (40) @(posedge core_clk);
		rd(5'h17, udr(1'b1));
		wr(5'h17, model);
		rd(5'h17, udr(1'b0));
		print_verdict();
	end
endmodule // user_sense_enable_pins_test
